/* File: fem_map.svh */
// Constants for the frame error monitor: widths, limits and timing counts
`ifndef FEM_MAP_SVH
`define FEM_MAP_SVH

`define FEM_CNT_W        17
`define FEM_CNT_MAX      17'h1869F
`define FEM_MIN_MINUTES  11'h005
`define FEM_MAX_MINUTES  11'h5A0
`define FEM_MIN_W        11
`define FEM_SEC_PER_MIN  6'h3B
`define FEM_BER_MIN_ERR  17'h0000A
`define FEM_AIS_WIN      12'hC0F
`define FEM_AIS_ZERO_MAX 12'h003

`endif

/* File: fem_pkg.sv */
// Types shared by the frame error monitor files
package fem_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_DONE = 2'b11
    } meas_state_t;

    typedef enum logic [1:0] {
        STRUCT_NONE = 2'b00,
        STRUCT_12   = 2'b01,
        STRUCT_24   = 2'b10
    } struct_t;
endpackage : fem_pkg

/* File: frame_error_monitor.sv */
// Frame error monitor: timer, counters, errored seconds, latched alarms
`timescale 1ns/1ps
`include "fem_map.svh"

////////////////////////////////////////////////////////////////////////////////
module frame_error_monitor #(
    parameter int CW = `FEM_CNT_W,
    parameter int MW = `FEM_MIN_W
) (
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          sec_tick,
    input  wire logic          sel_24,
    input  wire logic          start,
    input  wire logic          stop,
    input  wire logic          continuous,
    input  wire logic [MW-1:0] duration_min,
    input  wire logic          frm_bit_err,
    input  wire logic          crc_err,
    input  wire logic          frame_lost,
    input  wire logic          mf12_seen,
    input  wire logic          mf24_seen,
    input  wire logic          bit_valid,
    input  wire logic          bit_data,
    input  wire logic          code_viol,
    input  wire logic          far_end_alarm_signal,
    input  wire logic          slot_bit,
    input  wire logic [4:0]    slot_sel,
    input  wire logic [4:0]    slot_now,
    input  wire logic [4:0]    clr_cnt,
    input  wire logic          clr_alarms,
    output logic [CW-1:0]      frm_err_cnt,
    output logic [CW-1:0]      frm_es_cnt,
    output logic [CW-1:0]      crc_err_cnt,
    output logic [CW-1:0]      crc_es_cnt,
    output logic [CW-1:0]      lof_cnt,
    output logic [4:0]         cnt_ovf,
    output logic               running,
    output logic               meas_done,
    output logic               ber_valid,
    output logic [CW-1:0]      ber_errors,
    output logic [CW-1:0]      ber_seconds,
    output logic               lof_ind,
    output logic               lof_latched,
    output logic               ais_latched,
    output logic               far_alarm_latched,
    output logic [1:0]         struct_seen,
    output logic               slot_out,
    output logic               slot_out_valid
);
    ////////////////////////////////////////////////////////////////////////////
    // Measurement timer
    fem_pkg::meas_state_t st_reg, st_next;
    logic [5:0]    sec_reg, sec_next;
    logic [MW-1:0] min_reg, min_next;
    logic [MW-1:0] dur_lim;

    always_comb begin
        if (duration_min < MW'(`FEM_MIN_MINUTES))
            dur_lim = MW'(`FEM_MIN_MINUTES);
        else if (duration_min > MW'(`FEM_MAX_MINUTES))
            dur_lim = MW'(`FEM_MAX_MINUTES);
        else
            dur_lim = duration_min;
    end

    always_comb begin
        st_next  = st_reg;
        sec_next = sec_reg;
        min_next = min_reg;
        case (st_reg)
            fem_pkg::ST_IDLE, fem_pkg::ST_DONE: begin
                if (start) begin
                    st_next  = fem_pkg::ST_RUN;
                    sec_next = '0;
                    min_next = '0;
                end
            end
            fem_pkg::ST_RUN: begin
                if (stop) begin
                    st_next = fem_pkg::ST_DONE;
                end else if (sec_tick && !continuous) begin
                    if (sec_reg == `FEM_SEC_PER_MIN) begin
                        sec_next = '0;
                        min_next = min_reg + MW'(1);
                        if (min_reg + MW'(1) >= dur_lim)
                            st_next = fem_pkg::ST_DONE;
                    end else begin
                        sec_next = sec_reg + 6'h01;
                    end
                end
            end
            default: st_next = fem_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg  <= fem_pkg::ST_IDLE;
            sec_reg <= '0;
            min_reg <= '0;
        end else begin
            st_reg  <= st_next;
            sec_reg <= sec_next;
            min_reg <= min_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counting gates and errored-second flags
    logic active;
    logic gate;
    logic lof_prev_reg;
    logic frm_flag_reg, frm_flag_next;
    logic crc_flag_reg, crc_flag_next;
    logic inc_frm_es, inc_crc_es, lof_entry;

    assign active    = (st_reg == fem_pkg::ST_RUN);
    assign gate      = active && !frame_lost;
    assign lof_entry = active && frame_lost && !lof_prev_reg;

    assign inc_frm_es = gate && sec_tick && (frm_flag_reg || frm_bit_err);
    assign inc_crc_es = gate && sec_tick && sel_24
                        && (crc_flag_reg || crc_err);

    always_comb begin
        frm_flag_next = frm_flag_reg;
        crc_flag_next = crc_flag_reg;
        if (sec_tick || !active) begin
            frm_flag_next = 1'b0;
            crc_flag_next = 1'b0;
        end else if (gate) begin
            if (frm_bit_err)
                frm_flag_next = 1'b1;
            if (crc_err && sel_24)
                crc_flag_next = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            frm_flag_reg <= 1'b0;
            crc_flag_reg <= 1'b0;
            lof_prev_reg <= 1'b0;
        end else begin
            frm_flag_reg <= frm_flag_next;
            crc_flag_reg <= crc_flag_next;
            lof_prev_reg <= frame_lost;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Count registers
    logic [4:0]    inc_vec;
    logic [CW-1:0] cnt_w [5];
    logic [4:0]    ovf_w;

    assign inc_vec = {lof_entry, inc_crc_es, gate && crc_err && sel_24,
                      inc_frm_es, gate && frm_bit_err};

    for (genvar i = 0; i < 5; i++) begin : g_cnt
        sat_counter #(.W(CW)) u_cnt (
            .mclk     (mclk),
            .rst      (rst),
            .clear    (clr_cnt[i]),
            .inc      (inc_vec[i]),
            .count    (cnt_w[i]),
            .overflow (ovf_w[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Error ratio estimate
    logic [CW-1:0] ber_e_reg, ber_e_next;
    logic [CW-1:0] ber_s_reg, ber_s_next;

    always_comb begin
        ber_e_next = ber_e_reg;
        ber_s_next = ber_s_reg;
        if (active && sel_24 && !frame_lost) begin
            if (crc_err && ber_e_reg != CW'(`FEM_CNT_MAX))
                ber_e_next = ber_e_reg + CW'(1);
            if (sec_tick && ber_s_reg != CW'(`FEM_CNT_MAX))
                ber_s_next = ber_s_reg + CW'(1);
        end
        if (start && !active) begin
            ber_e_next = '0;
            ber_s_next = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Alarm detection and latches
    logic [11:0] ais_win_reg, ais_win_next;
    logic [11:0] ais_zero_reg, ais_zero_next;
    logic        ais_lat_next, far_lat_next, lof_lat_next;
    logic        ais_hit;

    always_comb begin
        ais_win_next  = ais_win_reg;
        ais_zero_next = ais_zero_reg;
        ais_hit       = 1'b0;
        if (bit_valid) begin
            if (ais_win_reg == `FEM_AIS_WIN) begin
                ais_hit       = (ais_zero_reg <= `FEM_AIS_ZERO_MAX);
                ais_win_next  = '0;
                ais_zero_next = '0;
            end else begin
                ais_win_next = ais_win_reg + 12'h001;
                if (!bit_data && !code_viol)
                    ais_zero_next = ais_zero_reg + 12'h001;
            end
        end
    end

    always_comb begin
        ais_lat_next = ais_hit || (ais_latched && !clr_alarms);
        far_lat_next = far_end_alarm_signal
                       || (far_alarm_latched && !clr_alarms);
        lof_lat_next = frame_lost || (lof_latched && !clr_alarms);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            ais_win_reg       <= '0;
            ais_zero_reg      <= '0;
            ber_e_reg         <= '0;
            ber_s_reg         <= '0;
            frm_err_cnt       <= '0;
            frm_es_cnt        <= '0;
            crc_err_cnt       <= '0;
            crc_es_cnt        <= '0;
            lof_cnt           <= '0;
            cnt_ovf           <= '0;
            running           <= 1'b0;
            meas_done         <= 1'b0;
            ber_valid         <= 1'b0;
            ber_errors        <= '0;
            ber_seconds       <= '0;
            lof_ind           <= 1'b0;
            lof_latched       <= 1'b0;
            ais_latched       <= 1'b0;
            far_alarm_latched <= 1'b0;
            struct_seen       <= fem_pkg::STRUCT_NONE;
            slot_out          <= 1'b0;
            slot_out_valid    <= 1'b0;
        end else begin
            ais_win_reg       <= ais_win_next;
            ais_zero_reg      <= ais_zero_next;
            ber_e_reg         <= ber_e_next;
            ber_s_reg         <= ber_s_next;
            frm_err_cnt       <= cnt_w[0];
            frm_es_cnt        <= cnt_w[1];
            crc_err_cnt       <= cnt_w[2];
            crc_es_cnt        <= cnt_w[3];
            lof_cnt           <= cnt_w[4];
            cnt_ovf           <= ovf_w;
            running           <= active;
            meas_done         <= (st_reg == fem_pkg::ST_DONE);
            ber_valid         <= (ber_e_reg >= `FEM_BER_MIN_ERR);
            ber_errors        <= ber_e_reg;
            ber_seconds       <= ber_s_reg;
            lof_ind           <= frame_lost;
            lof_latched       <= lof_lat_next;
            ais_latched       <= ais_lat_next;
            far_alarm_latched <= far_lat_next;
            if (mf24_seen)
                struct_seen <= fem_pkg::STRUCT_24;
            else if (mf12_seen)
                struct_seen <= fem_pkg::STRUCT_12;
            else
                struct_seen <= fem_pkg::STRUCT_NONE;
            slot_out_valid    <= bit_valid && (slot_now == slot_sel);
            if (bit_valid && slot_now == slot_sel)
                slot_out <= slot_bit;
        end
    end
endmodule : frame_error_monitor

/* File: frame_error_monitor_props.sv */
// Port checker for the frame error monitor
`timescale 1ns/1ps
`include "fem_map.svh"
module frame_error_monitor_props #(
    parameter int CW = `FEM_CNT_W
) (
    input wire logic          mclk,
    input wire logic          rst,
    input wire logic          sec_tick,
    input wire logic          sel_24,
    input wire logic          start,
    input wire logic          stop,
    input wire logic          frm_bit_err,
    input wire logic          crc_err,
    input wire logic          frame_lost,
    input wire logic [4:0]    clr_cnt,
    input wire logic          clr_alarms,
    input wire logic [CW-1:0] frm_err_cnt,
    input wire logic [CW-1:0] frm_es_cnt,
    input wire logic [CW-1:0] crc_err_cnt,
    input wire logic          running,
    input wire logic          lof_latched
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    property p_frm_inc;
        frm_bit_err && !frame_lost && !clr_cnt[0] ##1 running |=>
            frm_err_cnt == $past(frm_err_cnt) + 1'b1
            || frm_err_cnt == `FEM_CNT_MAX;
    endproperty
    a_frm_inc: assert property (p_frm_inc) else $error("bit missed");
    property p_frm_lost;
        frm_bit_err && frame_lost && !clr_cnt[0] |=> ##1 $stable(frm_err_cnt);
    endproperty
    a_frm_lost: assert property (p_frm_lost) else $error("lost count");
    property p_crc_12;
        crc_err && !sel_24 && !clr_cnt[2] |=> ##1 $stable(crc_err_cnt);
    endproperty
    a_crc_12: assert property (p_crc_12) else $error("crc in 12");
    property p_es_tick;
        !sec_tick && !clr_cnt[1] |=> ##1 $stable(frm_es_cnt);
    endproperty
    a_es_tick: assert property (p_es_tick) else $error("es no tick");
    property p_clr;
        clr_cnt[1] |=> ##1 frm_es_cnt == 17'h00000;
    endproperty
    a_clr: assert property (p_clr) else $error("clear lost");
    property p_indep;
        clr_cnt[0] && !clr_cnt[2] && !crc_err |=> ##1 $stable(crc_err_cnt);
    endproperty
    a_indep: assert property (p_indep) else $error("clear spread");
    property p_latch;
        lof_latched && !clr_alarms && !$past(clr_alarms) |=> lof_latched;
    endproperty
    a_latch: assert property (p_latch) else $error("latch dropped");
    property p_start;
        start && !stop && !running && !$past(start) |=> ##1 running;
    endproperty
    a_start: assert property (p_start) else $error("start lost");
    property p_stop;
        stop ##1 running |=> !running;
    endproperty
    a_stop: assert property (p_stop) else $error("stop lost");
    c_frm: cover property (frm_bit_err && running);
    c_tick: cover property (sec_tick && frm_es_cnt != 17'h00000);
    c_lost: cover property (frame_lost && running);
endmodule : frame_error_monitor_props

bind frame_error_monitor frame_error_monitor_props #(.CW(CW)) i_props (
    .mclk, .rst, .sec_tick, .sel_24, .start, .stop, .frm_bit_err, .crc_err,
    .frame_lost, .clr_cnt, .clr_alarms, .frm_err_cnt, .frm_es_cnt,
    .crc_err_cnt, .running, .lof_latched);

/* File: frame_error_monitor_test.sv */
// Directed test of the frame error monitor
`timescale 1ns/1ps
module frame_error_monitor_test;
    logic        mclk, rst, sec_tick, sel_24, start, stop, continuous;
    logic        frm_bit_err, crc_err, frame_lost, bit_valid, bit_data;
    logic        code_viol, mf12_seen, mf24_seen, far_end_alarm_signal;
    logic        slot_bit, clr_alarms, running, meas_done, ber_valid;
    logic        lof_ind, lof_latched, ais_latched, far_alarm_latched;
    logic        slot_out, slot_out_valid;
    logic [1:0]  struct_seen;
    logic [4:0]  slot_sel, slot_now, clr_cnt, cnt_ovf;
    logic [10:0] duration_min;
    logic [16:0] frm_err_cnt, frm_es_cnt, crc_err_cnt, crc_es_cnt, lof_cnt;
    logic [16:0] ber_errors, ber_seconds;
    int          err_count, n_compared;

    frame_error_monitor i_dut (.mclk, .rst, .sec_tick, .sel_24, .start,
        .stop, .continuous, .duration_min, .frm_bit_err, .crc_err,
        .frame_lost, .mf12_seen, .mf24_seen, .bit_valid, .bit_data,
        .code_viol, .far_end_alarm_signal, .slot_bit, .slot_sel, .slot_now,
        .clr_cnt, .clr_alarms, .frm_err_cnt, .frm_es_cnt, .crc_err_cnt,
        .crc_es_cnt, .lof_cnt, .cnt_ovf, .running, .meas_done, .ber_valid,
        .ber_errors, .ber_seconds, .lof_ind, .lof_latched, .ais_latched,
        .far_alarm_latched, .struct_seen, .slot_out, .slot_out_valid);
    line_model i_line (.mclk, .frm_bit_err, .crc_err, .frame_lost,
        .bit_valid, .bit_data, .code_viol);

    always #20 mclk = ~mclk;
    ////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    task automatic chk(input logic [16:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    // Trailing #1 lets the edge's register updates land before sampling
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc

    task automatic cmd(input logic go, halt);
        @(posedge mclk);
        start <= go;
        stop  <= halt;
        @(posedge mclk);
        start <= 1'b0;
        stop  <= 1'b0;
    endtask : cmd

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge mclk);
            sec_tick <= 1'b1;
            @(posedge mclk);
            sec_tick <= 1'b0;
        end
    endtask : tick

    task automatic clr(input logic [4:0] m, input logic a);
        @(posedge mclk);
        clr_cnt    <= m;
        clr_alarms <= a;
        @(posedge mclk);
        clr_cnt    <= 5'h00;
        clr_alarms <= 1'b0;
    endtask : clr

    // Step off the edge first so a value still settling is not taken
    task automatic wait_run(input logic v);
        #1;
        for (int i = 0; i < 20 && running !== v; i++) cyc(1);
        chk(running, v);
        if (running !== v) summarize();
    endtask : wait_run
    ////////////////////////////////////////////////////////////
    initial begin
        {mclk, sec_tick, sel_24, start, stop, continuous, clr_alarms} = '0;
        {mf12_seen, mf24_seen, far_end_alarm_signal, slot_bit} = '0;
        {slot_sel, slot_now, clr_cnt} = '0;
        duration_min = 11'h005;
        err_count = 0;
        n_compared = 0;
        rst = 1'b1;
        repeat (8) @(posedge mclk);
        rst        <= 1'b0;
        sel_24     <= 1'b1;
        continuous <= 1'b1;
        cmd(1'b1, 1'b0);
        wait_run(1'b1);
        i_line.errs(3, 2, 0);
        cyc(3);
        chk(frm_err_cnt, 17'h00003);
        chk(crc_err_cnt, 17'h00002);
        chk(ber_valid, 1'b0);
        tick(1);
        cyc(3);
        chk(frm_es_cnt, 17'h00001);
        chk(crc_es_cnt, 17'h00001);
        i_line.errs(8, 8, 2);
        cyc(3);
        chk(ber_valid, 1'b1);
        chk(ber_errors, 17'h0000A);
        chk(ber_seconds, 17'h00001);
        i_line.lose(1'b1);
        i_line.errs(2, 2, 0);
        cyc(3);
        chk(lof_cnt, 17'h00001);
        chk(frm_err_cnt, 17'h0000B);
        i_line.lose(1'b0);
        cyc(3);
        chk(lof_ind, 1'b0);
        chk(lof_latched, 1'b1);
        clr(5'h00, 1'b1);
        cyc(3);
        chk(lof_latched, 1'b0);
        @(posedge mclk);
        sel_24 <= 1'b0;
        i_line.errs(1, 1, 0);
        cyc(3);
        chk(crc_err_cnt, 17'h0000A);
        clr(5'h01, 1'b0);
        cyc(3);
        chk(frm_err_cnt, 17'h00000);
        chk(crc_err_cnt, 17'h0000A);
        cmd(1'b0, 1'b1);
        wait_run(1'b0);
        i_line.errs(2, 0, 0);
        cyc(3);
        chk(frm_err_cnt, 17'h00000);
        // Two minutes asked for; the shortest timer is five minutes
        @(posedge mclk);
        continuous   <= 1'b0;
        duration_min <= 11'h002;
        clr(5'h1F, 1'b0);
        cmd(1'b1, 1'b0);
        wait_run(1'b1);
        tick(299);
        cyc(3);
        chk(running, 1'b1);
        tick(1);
        wait_run(1'b0);
        chk(meas_done, 1'b1);
        i_line.errs(1, 0, 0);
        cyc(3);
        chk(frm_err_cnt, 17'h00000);
        chk(cnt_ovf, 5'h00);
        @(posedge mclk);
        mf24_seen            <= 1'b1;
        far_end_alarm_signal <= 1'b1;
        slot_sel             <= 5'h03;
        slot_now             <= 5'h03;
        slot_bit             <= 1'b1;
        i_line.ones(3200);
        // Last bit was taken on the edge that ended the run
        cyc(0);
        chk(slot_out_valid, 1'b1);
        chk(slot_out, 1'b1);
        cyc(4);
        chk(slot_out_valid, 1'b0);
        chk(struct_seen, fem_pkg::STRUCT_24);
        chk(ais_latched, 1'b1);
        chk(far_alarm_latched, 1'b1);
        // Other slot and a dropped far-end alarm: slot_out and far_alarm_latched must hold
        @(posedge mclk);
        slot_now             <= 5'h04;
        slot_bit             <= 1'b0;
        far_end_alarm_signal <= 1'b0;
        mf24_seen            <= 1'b0;
        mf12_seen            <= 1'b1;
        i_line.ones(2);
        cyc(0);
        chk(slot_out_valid, 1'b0);
        chk(slot_out, 1'b1);
        chk(struct_seen, fem_pkg::STRUCT_12);
        chk(far_alarm_latched, 1'b1);
        @(posedge mclk);
        mf12_seen <= 1'b0;
        clr(5'h00, 1'b1);
        cyc(3);
        chk(ais_latched, 1'b0);
        chk(far_alarm_latched, 1'b0);
        chk(struct_seen, fem_pkg::STRUCT_NONE);
        summarize();
    end
endmodule : frame_error_monitor_test

/* File: line_model.sv */
// Behavioural model of the monitored, already frame-aligned line
`timescale 1ns/1ps
module line_model (
    input  wire logic mclk,
    output logic      frm_bit_err,
    output logic      crc_err,
    output logic      frame_lost,
    output logic      bit_valid,
    output logic      bit_data,
    output logic      code_viol
);
    initial begin
        {frm_bit_err, crc_err, frame_lost} = 3'h0;
        {bit_valid, bit_data, code_viol} = 3'h0;
    end

    // Back to back pulses when gap is 0, spaced out otherwise
    task automatic errs(input int nf, nc, gap);
        for (int i = 0; i < nf || i < nc; i++) begin
            @(posedge mclk);
            frm_bit_err <= (i < nf);
            crc_err     <= (i < nc);
            repeat (gap) begin
                @(posedge mclk);
                frm_bit_err <= 1'b0;
                crc_err     <= 1'b0;
            end
        end
        @(posedge mclk);
        frm_bit_err <= 1'b0;
        crc_err     <= 1'b0;
    endtask : errs

    task automatic lose(input logic v);
        @(posedge mclk);
        frame_lost <= v;
    endtask : lose

    // One violated bit, at index 1000, in all-ones runs longer than 1000 bits; line idles at the inverse
    task automatic ones(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            bit_valid <= 1'b1;
            bit_data  <= (i != 1000);
            code_viol <= (i == 1000);
        end
        @(posedge mclk);
        {bit_valid, bit_data, code_viol} <= 3'h0;
    endtask : ones
endmodule : line_model

/* File: sat_counter.sv */
// Saturating event counter with overflow flag and its own clear
`timescale 1ns/1ps
`include "fem_map.svh"

module sat_counter #(
    parameter int W = `FEM_CNT_W
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         clear,
    input  wire logic         inc,
    output logic [W-1:0]      count,
    output logic              overflow
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         ovf_reg;
    logic         ovf_next;

    always_comb begin
        cnt_next = cnt_reg;
        ovf_next = ovf_reg;
        if (clear) begin
            cnt_next = '0;
            ovf_next = 1'b0;
        end else if (inc) begin
            if (cnt_reg == W'(`FEM_CNT_MAX)) begin
                ovf_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + W'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_reg <= '0;
            ovf_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            ovf_reg <= ovf_next;
        end
    end

    assign count    = cnt_reg;
    assign overflow = ovf_reg;
endmodule : sat_counter
